// ==== common/ptr_move_defs.svh ====
`ifndef PTR_MOVE_DEFS_SVH
`define PTR_MOVE_DEFS_SVH

// ------------------------------------------------------------
// instruction encodings, address forming constants and register bit positions
// ------------------------------------------------------------
`define LOAD_PTR_OP1 6'h3b
`define LOAD_PTR_OP2 8'hf0
`define MOVE_FILE_OP 6'h14
`define IDX_LIMIT 8'h5f
`define ACCESS_SPLIT 8'h60
`define ACCESS_HI_BANK 4'hf
`define PTR_COUNT 2'h3
`define ACCESS_LO_BANK 4'h0
`define CTRL_EXT_BIT 8
`define STAT_CLR_BIT 2

// ------------------------------------------------------------
// apb register offsets
// ------------------------------------------------------------
`define A_INSTR 12'h000
`define A_CTRL 12'h004
`define A_WREG 12'h008
`define A_STATUS 12'h00c
`define A_PTR0 12'h010
`define A_PTR1 12'h014
`define A_PTR2 12'h018
`define A_FILE_ADDR 12'h01c
`define A_FILE_DATA 12'h020

`endif

// ==== common/ptr_move_pkg.sv ====
package ptr_move_pkg;
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic we;
   } file_req_s;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOAD2 = 2'b01,
      ST_ERR = 2'b10
   } dec_state_e;
endpackage : ptr_move_pkg

// ==== hw/file_ram.sv ====
`timescale 1ns/10ps
module file_ram (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RST_N,
   // access port
   input wire ptr_move_pkg::file_req_s req,
   output logic [7:0] rdata
);
   // 4 kib file space; read is combinational so a move finishes in one cycle
   logic [7:0] mem [0:4095];

   assign rdata = mem[req.addr];

   always_ff @(posedge CLOCK) begin
      if (req.we) begin
         mem[req.addr] <= req.wdata;
      end
   end
endmodule : file_ram

// ==== hw/ptr_move_core.sv ====
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`include "ptr_move_defs.svh"
// What this block does
// - load 12-bit literal into pointer 0..2, flags untouched
// - decode two-word load, second word starts 11110000
// - move file to W or back, set N/Z
// - bank bit picks access bank or selected bank
// - 8-bit address spans whole 256-byte bank
// - extended set, a=0, f<=95 uses indexed offset
module ptr_move_core
   import ptr_move_pkg::*;
(
   // clock and reset
   input wire logic CLOCK,
   input wire logic RST_N,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR
);

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   function automatic logic [11:0] pick_ptr(input logic [1:0] sel, input logic [11:0] p0,
                                            input logic [11:0] p1, input logic [11:0] p2);
      logic [11:0] r;
      r = p0;
      if (sel == 2'h1) begin
         r = p1;
      end else if (sel == 2'h2) begin
         r = p2;
      end
      return r;
   endfunction : pick_ptr

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   dec_state_e state_r, state_nxt;
   logic [11:0] ptr_r [0:2];
   logic [1:0] sel_r;
   logic [7:0] wreg_r;
   logic [3:0] bank_r;
   logic ext_en_r;
   logic neg_r, zero_r;
   logic bad_r;
   logic [31:0] prdata_r;
   logic [7:0] dbg_data;
   file_req_s req;

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   wire acc = PSEL && PENABLE;
   wire wr = acc && PWRITE;
   wire wr_instr = wr && (PADDR == `A_INSTR);
   wire wr_ctrl = wr && (PADDR == `A_CTRL);
   wire wr_wreg = wr && (PADDR == `A_WREG);
   wire wr_fdata = wr && (PADDR == `A_FILE_DATA);
   wire wr_status = wr && (PADDR == `A_STATUS);
   wire wr_faddr = wr && (PADDR == `A_FILE_ADDR);
   logic [11:0] dbg_addr_r;
   wire [15:0] iw = PWDATA[15:0];

   // ------------------------------------------------------------
   // instruction decode
   // ------------------------------------------------------------
   wire is_load1 = wr_instr && (state_r == ST_IDLE) && (iw[15:10] == `LOAD_PTR_OP1)
                   && (iw[7:4] == 4'h0) && (iw[9:8] != `PTR_COUNT);
   wire is_load2 = wr_instr && (state_r == ST_LOAD2) && (iw[15:8] == `LOAD_PTR_OP2);
   wire bad_load2 = wr_instr && (state_r == ST_LOAD2) && (iw[15:8] != `LOAD_PTR_OP2);
   wire is_move = wr_instr && (state_r == ST_IDLE) && (iw[15:10] == `MOVE_FILE_OP);
   wire mv_d = iw[9];
   wire mv_a = iw[8];
   wire [7:0] mv_f = iw[7:0];
   wire use_idx = !mv_a && ext_en_r && (mv_f <= `IDX_LIMIT);
   wire [11:0] idx_addr = ptr_r[2] + {4'h0, mv_f};
   wire [3:0] acc_bank = (mv_f < `ACCESS_SPLIT) ? `ACCESS_LO_BANK : `ACCESS_HI_BANK;
   wire [11:0] dir_addr = mv_a ? {bank_r, mv_f} : {acc_bank, mv_f};
   wire [11:0] mv_addr = use_idx ? idx_addr : dir_addr;
   wire [7:0] mv_val = dbg_data;
   wire unknown = wr_instr && (state_r == ST_IDLE) && !is_load1 && !is_move;

   // file space port: move execution has priority over debug access
   always_comb begin
      req.addr = dbg_addr_r;
      req.wdata = PWDATA[7:0];
      req.we = wr_fdata;
      if (is_move) begin
         req.addr = mv_addr;
         req.wdata = mv_val;
         req.we = mv_d;
      end
   end

   file_ram u_ram (
      .CLOCK(CLOCK),
      .RST_N(RST_N),
      .req(req),
      .rdata(dbg_data)
   );

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (is_load1) begin
               state_nxt = ST_LOAD2;
            end
         end
         ST_LOAD2: begin
            if (wr_instr) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         state_r <= ST_IDLE;
         sel_r <= 2'h0;
      end else begin
         state_r <= state_nxt;
         if (is_load1) begin
            sel_r <= iw[9:8];
         end
      end
   end

   // pointers: high nibble first, low byte on the second word
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         ptr_r[0] <= 12'h000;
         ptr_r[1] <= 12'h000;
         ptr_r[2] <= 12'h000;
      end else if (is_load1) begin
         ptr_r[iw[9:8]][11:8] <= iw[3:0];
      end else if (is_load2) begin
         ptr_r[sel_r][7:0] <= iw[7:0];
      end
   end

   // a bad second word abandons the load; the high nibble already written stays
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         wreg_r <= 8'h00;
         neg_r <= 1'b0;
         zero_r <= 1'b0;
      end else if (is_move) begin
         if (!mv_d) begin
            wreg_r <= mv_val;
         end
         neg_r <= mv_val[7];
         zero_r <= (mv_val == 8'h00);
      end else if (wr_wreg) begin
         wreg_r <= PWDATA[7:0];
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         bank_r <= 4'h0;
         ext_en_r <= 1'b0;
         bad_r <= 1'b0;
         dbg_addr_r <= 12'h000;
      end else begin
         if (wr_ctrl) begin
            bank_r <= PWDATA[3:0];
            ext_en_r <= PWDATA[`CTRL_EXT_BIT];
         end
         if (wr_faddr) begin
            dbg_addr_r <= PWDATA[11:0];
         end
         if (unknown || bad_load2) begin
            bad_r <= 1'b1;
         end else if (wr_status && PWDATA[`STAT_CLR_BIT]) begin
            bad_r <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   logic [31:0] rd_mux;
   always_comb begin
      case (PADDR)
         `A_CTRL: rd_mux = {23'h0, ext_en_r, 4'h0, bank_r};
         `A_WREG: rd_mux = {24'h0, wreg_r};
         `A_STATUS: rd_mux = {28'h0, (state_r == ST_LOAD2), bad_r, zero_r, neg_r};
         `A_PTR0: rd_mux = {20'h0, ptr_r[0]};
         `A_PTR1: rd_mux = {20'h0, ptr_r[1]};
         `A_PTR2: rd_mux = {20'h0, ptr_r[2]};
         `A_FILE_ADDR: rd_mux = {20'h0, dbg_addr_r};
         `A_FILE_DATA: rd_mux = {24'h0, dbg_data};
         `A_INSTR: rd_mux = {20'h0, pick_ptr(sel_r, ptr_r[0], ptr_r[1], ptr_r[2])};
         default: rd_mux = 32'h0;
      endcase
   end

   wire mapped = (PADDR <= `A_FILE_DATA) && (PADDR[1:0] == 2'h0);

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         prdata_r <= 32'h0;
      end else if (PSEL && !PENABLE) begin
         prdata_r <= rd_mux;
      end
   end

   assign PRDATA = prdata_r;
   assign PREADY = 1'b1;
   assign PSLVERR = acc && !mapped;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_load_flags_kept: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (is_load1 || is_load2) |=> $stable(neg_r) && $stable(zero_r))
      else $error("pointer load changed flags");
   a_load_two_words: assert property (@(posedge CLOCK) disable iff (!RST_N)
      is_load1 |=> state_r == ST_LOAD2)
      else $error("load did not wait for second word");
   a_low_byte_write: assert property (@(posedge CLOCK) disable iff (!RST_N)
      is_load2 |=> ptr_r[$past(sel_r)][7:0] == $past(iw[7:0]))
      else $error("low byte not written");
   a_move_to_w: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (is_move && !mv_d) |=> wreg_r == $past(mv_val) && zero_r == ($past(mv_val) == 8'h00))
      else $error("move to W wrong");
   a_bank_select: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (is_move && mv_a) |-> req.addr == {bank_r, mv_f})
      else $error("bank select address wrong");
   a_access_low: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (is_move && !mv_a && !use_idx) |-> req.addr[7:0] == mv_f)
      else $error("access bank offset wrong");
   a_indexed_mode: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (is_move && !mv_a && ext_en_r && mv_f <= `IDX_LIMIT) |-> req.addr == ptr_r[2] + {4'h0, mv_f})
      else $error("indexed offset address wrong");
   a_neg_flag: assert property (@(posedge CLOCK) disable iff (!RST_N)
      is_move |=> neg_r == $past(mv_val[7]))
      else $error("negative flag wrong");

   // pointer load: nibble first, byte second, nothing else touched
   a_load_high_nibble: assert property (@(posedge CLOCK) disable iff (!RST_N)
      is_load1 |=> ptr_r[$past(iw[9:8])][11:8] == $past(iw[3:0]))
      else $error("high nibble not written");
   a_high_kept_low: assert property (@(posedge CLOCK) disable iff (!RST_N)
      is_load2 |=> ptr_r[$past(sel_r)][11:8] == $past(ptr_r[sel_r][11:8]))
      else $error("low byte write disturbed high nibble");
   a_sel_captured: assert property (@(posedge CLOCK) disable iff (!RST_N)
      is_load1 |=> sel_r == $past(iw[9:8]))
      else $error("pointer selector not kept");
   a_load_w_kept: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (is_load1 || is_load2) |=> $stable(wreg_r))
      else $error("pointer load changed W");
   a_second_word_done: assert property (@(posedge CLOCK) disable iff (!RST_N)
      is_load2 |=> state_r == ST_IDLE)
      else $error("load did not finish on second word");
   a_bad_word_abort: assert property (@(posedge CLOCK) disable iff (!RST_N)
      bad_load2 |=> state_r == ST_IDLE && bad_r)
      else $error("bad second word not abandoned");
   a_bad_word_no_low: assert property (@(posedge CLOCK) disable iff (!RST_N)
      bad_load2 |=> $stable(ptr_r[0]) && $stable(ptr_r[1]) && $stable(ptr_r[2]))
      else $error("bad second word wrote a pointer");
   // the error flag must win over a clear that lands in the same cycle
   a_error_set_wins: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (unknown || bad_load2) |=> bad_r)
      else $error("decode error not flagged");

   // file move: destination, flags and address forming
   a_move_back_file: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (is_move && mv_d) |-> req.we && req.wdata == dbg_data)
      else $error("move back to file not written");
   a_move_back_w_kept: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (is_move && mv_d) |=> $stable(wreg_r))
      else $error("move back to file changed W");
   a_zero_flag: assert property (@(posedge CLOCK) disable iff (!RST_N)
      is_move |=> zero_r == ($past(mv_val) == 8'h00))
      else $error("zero flag wrong");
   a_flags_only_move: assert property (@(posedge CLOCK) disable iff (!RST_N)
      !is_move |=> $stable(neg_r) && $stable(zero_r))
      else $error("flags changed without a move");
   a_access_bank_hi: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (is_move && !mv_a && !use_idx)
         |-> req.addr[11:8] == ((mv_f < `ACCESS_SPLIT) ? `ACCESS_LO_BANK : `ACCESS_HI_BANK))
      else $error("access bank wrong");
   a_bank_offset: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (is_move && mv_a) |-> req.addr[7:0] == mv_f)
      else $error("banked offset wrong");
   a_no_idx_above: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (is_move && !mv_a && mv_f > `IDX_LIMIT) |-> req.addr[7:0] == mv_f)
      else $error("indexed mode used above limit");
   a_slverr_range: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (acc && PADDR > `A_FILE_DATA) |-> PSLVERR)
      else $error("unmapped access not refused");
endmodule : ptr_move_core

// ==== tb/pointer_load_and_move_decode_test.sv ====
`timescale 1ns/10ps
`include "ptr_move_defs.svh"
module pointer_load_and_move_decode_test
   import ptr_move_pkg::*;
;
// ---------------------------------------------
// bench signals
// ---------------------------------------------
logic CLOCK, RST_N, PSEL, PENABLE, PWRITE;
logic [11:0] PADDR, k, p2, ea;
logic [31:0] PWDATA, rd, seed, w_exp;
wire [31:0] PRDATA;
wire PREADY, PSLVERR;
logic er, a, d, ext;
logic [7:0] f, v;
logic [3:0] bank;
int bad_count, samples_checked;
ptr_move_core i_dut (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
initial begin
   CLOCK = 1'b0;
   forever #10 CLOCK = ~CLOCK;
end
// ---------------------------------------------
// helpers
// ---------------------------------------------
task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
   samples_checked++;
   if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
   end
endtask : chk_word
task automatic chk_bit(input string what, input logic exp, input logic got);
   samples_checked++;
   if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
   end
endtask : chk_bit
// one idle cycle after each transfer keeps psel from being assigned twice in a step
task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] dt);
   int n;
   n = 0;
   PSEL <= 1'b1;
   PENABLE <= 1'b0;
   PWRITE <= w;
   PADDR <= ad;
   PWDATA <= dt;
   @(posedge CLOCK);
   PENABLE <= 1'b1;
   @(posedge CLOCK);
   while (PREADY !== 1'b1 && n < 100) begin
      n++;
      @(posedge CLOCK);
   end
   if (n == 100) chk_bit("pready", 1'b1, 1'b0);
   rd = PRDATA;
   er = PSLVERR;
   PSEL <= 1'b0;
   PENABLE <= 1'b0;
   @(posedge CLOCK);
endtask : apb
function automatic logic [31:0] load_pointer_literal(input logic [31:0] s);
   return {s[30:0], 1'b0} ^ (s[31] ? 32'h00400007 : 32'h0);
endfunction : load_pointer_literal
function automatic logic [11:0] eff_addr(input logic aa, input logic [7:0] ff, input logic [3:0] bk,
   input logic ex, input logic [11:0] ptr);
   if (aa) return {bk, ff};
   if (ex && ff <= `IDX_LIMIT) return ptr + {4'h0, ff};
   return (ff < `ACCESS_SPLIT) ? {4'h0, ff} : {`ACCESS_HI_BANK, ff};
endfunction : eff_addr
task automatic tally_and_finish();
   $display("compares %0d mismatches %0d", samples_checked, bad_count);
   if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
   else $display("MISMATCHES SEEN");
   $finish;
endtask : tally_and_finish
initial begin
   #200000;
   bad_count++;
   tally_and_finish();
end
// ---------------------------------------------
// main sequence
// ---------------------------------------------
initial begin
   {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
   RST_N = 1'b0;
   bad_count = 0;
   samples_checked = 0;
   seed = 32'h01024f05;
   w_exp = 32'h0;
   p2 = 12'h0;
   repeat (16) @(posedge CLOCK);
   RST_N <= 1'b1;
   @(posedge CLOCK);
   for (int i = 0; i < 7; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk_word("reset value", 32'h0, rd);
   end
   apb(1'b0, 12'h024, 32'h0);
   chk_bit("unmapped err", 1'b1, er);
   // pointer loads, corner literals first
   for (int i = 0; i < 9; i++) begin
      k = (i < 3) ? 12'hfff : (i < 6) ? 12'h000 : seed[11:0];
      seed = load_pointer_literal(seed);
      apb(1'b1, `A_INSTR, {16'h0, `LOAD_PTR_OP1, 2'(i % 3), 4'h0, k[11:8]});
      apb(1'b0, `A_STATUS, 32'h0);
      chk_bit("waiting second word", 1'b1, rd[3]);
      apb(1'b0, 12'(`A_PTR0 + 4 * (i % 3)), 32'h0);
      chk_word("pointer high", {28'h0, k[11:8]}, {28'h0, rd[11:8]});
      apb(1'b1, `A_INSTR, {16'h0, `LOAD_PTR_OP2, k[7:0]});
      apb(1'b0, 12'(`A_PTR0 + 4 * (i % 3)), 32'h0);
      chk_word("pointer", {20'h0, k}, rd);
      apb(1'b0, `A_INSTR, 32'h0);
      chk_word("selected pointer", {20'h0, k}, rd);
      apb(1'b0, `A_STATUS, 32'h0);
      chk_word("status after load", 32'h0, rd);
      if (i % 3 == 2) p2 = k;
   end
   // bad second word, then selector 3
   for (int i = 0; i < 2; i++) begin
      apb(1'b1, `A_INSTR, {16'h0, `LOAD_PTR_OP1, (i == 0) ? 2'h1 : 2'h3, 4'h0, 4'h5});
      if (i == 0) apb(1'b1, `A_INSTR, 32'h0000e012);
      apb(1'b0, `A_STATUS, 32'h0);
      chk_bit("decode error", 1'b1, rd[2]);
      chk_bit("load abandoned", 1'b0, rd[3]);
      apb(1'b1, `A_STATUS, 32'h4);
      apb(1'b0, `A_STATUS, 32'h0);
      chk_bit("error cleared", 1'b0, rd[2]);
   end
   // file moves with random and boundary addresses
   for (int i = 0; i < 24; i++) begin
      {v, f, bank, ext, d, a} = {seed[31:12], seed[10:8]};
      seed = load_pointer_literal(seed);
      if (i < 2) {a, ext, f} = {2'b01, 8'h5f + 8'(i)};
      if (i == 2) {a, v, f} = {1'b1, 8'h00, 8'hff};
      if (i == 3) {a, ext, f} = {2'b00, 8'h00};
      ea = eff_addr(a, f, bank, ext, p2);
      apb(1'b1, `A_CTRL, {23'h0, ext, 4'h0, bank});
      apb(1'b1, `A_FILE_ADDR, {20'h0, ea});
      apb(1'b1, `A_FILE_DATA, {24'h0, v});
      apb(1'b1, `A_INSTR, {16'h0, `MOVE_FILE_OP, d, a, f});
      if (!d) w_exp = {24'h0, v};
      apb(1'b0, `A_WREG, 32'h0);
      chk_word("w register", w_exp, rd);
      apb(1'b0, `A_STATUS, 32'h0);
      chk_word("n z flags", {30'h0, v == 8'h0, v[7]}, {30'h0, rd[1:0]});
      apb(1'b0, `A_FILE_DATA, 32'h0);
      chk_word("file value", {24'h0, v}, {24'h0, rd[7:0]});
   end
   // reset in mid-run: every register falls back at once
   RST_N <= 1'b0;
   repeat (2) @(posedge CLOCK);
   RST_N <= 1'b1;
   @(posedge CLOCK);
   for (int i = 0; i < 7; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk_word("reset again", 32'h0, rd);
   end
   tally_and_finish();
end
endmodule : pointer_load_and_move_decode_test
